// >>> pkg/profile_map.svh
`ifndef PROFILE_MAP_SVH
`define PROFILE_MAP_SVH

`define PRF_NUM_BLOCKS    8
`define PRF_BLK_W         3
`define PRF_TIME_W        40
`define PRF_COUNT_W       16
`define PRF_TASK_W        4
`define PRF_RESIDUE_W     8
`define PRF_CLK_PERIOD_NS 50
`define PRF_UNIT_NS       10
`define PRF_RES_MAX_NS    1600
// fine units gained per clock, and units in the slowest tick
`define PRF_STEP_UNITS    (`PRF_CLK_PERIOD_NS / `PRF_UNIT_NS)
`define PRF_SLOW_UNITS    (`PRF_RES_MAX_NS / `PRF_UNIT_NS)

`endif

// >>> pkg/profile_pkg.sv
`default_nettype none
package profile_pkg;

  // tick period selection
  typedef enum logic [2:0] {
    RES_10NS   = 3'b000,
    RES_20NS   = 3'b001,
    RES_40NS   = 3'b010,
    RES_80NS   = 3'b011,
    RES_160NS  = 3'b100,
    RES_1600NS = 3'b101
  } res_sel_e;

  // active block handling
  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_LOAD = 1'b1
  } prf_state_e;

endpackage
`default_nettype wire

// >>> logic/profile_result_mem.sv
`timescale 1ns/10ps
`default_nettype none
module profile_result_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int W     = 56
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          clear_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] ra_addr_i,
  output logic      [W-1:0]  ra_data_o,
  input  wire logic [AW-1:0] rb_addr_i,
  output logic      [W-1:0]  rb_data_o
);

  logic [W-1:0] mem_q [DEPTH];

  // storage; clear wins over a write in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (clear_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  // registered reads return the value before a same-cycle write
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ra_data_o <= '0;
      rb_data_o <= '0;
    end
    else
    begin
      ra_data_o <= mem_q[ra_addr_i];
      rb_data_o <= mem_q[rb_addr_i];
    end
  end

endmodule
`default_nettype wire

// >>> logic/realtime_profile_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "profile_map.svh"
module realtime_profile_counter #(
  parameter int NUM_BLOCKS = `PRF_NUM_BLOCKS,
  parameter int BLK_W      = `PRF_BLK_W,
  parameter int TIME_W     = `PRF_TIME_W,
  parameter int COUNT_W    = `PRF_COUNT_W,
  parameter int TASK_W     = `PRF_TASK_W
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  task_enter_i,
  input  wire logic [TASK_W-1:0]     task_id_i,
  input  wire logic                  task_run_i,
  input  wire logic                  sel_we_i,
  input  wire logic [TASK_W-1:0]     sel_id_i,
  input  wire logic                  sel_en_i,
  input  wire profile_pkg::res_sel_e res_sel_i,
  input  wire logic                  clear_i,
  input  wire logic                  brk_en_i,
  input  wire logic                  trc_en_i,
  input  wire logic                  rd_req_i,
  input  wire logic [BLK_W-1:0]      rd_block_i,
  output logic                       rd_valid_o,
  output logic                       rd_alloc_o,
  output logic      [TASK_W-1:0]     rd_task_o,
  output logic      [TIME_W-1:0]     rd_time_o,
  output logic      [COUNT_W-1:0]    rd_count_o,
  output logic                       blocks_full_o,
  output logic                       ovf_event_o,
  output logic                       ovf_flag_o,
  output logic                       ovf_break_o,
  output logic                       ovf_trace_o
);
  import profile_pkg::*;

  localparam int NUM_TASKS = 1 << TASK_W;
  localparam int RW        = `PRF_RESIDUE_W;
  localparam logic [TIME_W-1:0]  TIME_MAX  = '1;
  localparam logic [COUNT_W-1:0] COUNT_MAX = '1;
  localparam logic [RW-1:0] STEP_UNITS = RW'(`PRF_STEP_UNITS);
  localparam logic [RW-1:0] SLOW_UNITS = RW'(`PRF_SLOW_UNITS);

  // lowest set bit of a block vector
  function automatic logic [BLK_W-1:0] first_set(input logic [NUM_BLOCKS-1:0] v);
    logic [BLK_W-1:0] idx;
    idx = '0;
    for (int i = NUM_BLOCKS - 1; i >= 0; i--)
      if (v[i])
        idx = BLK_W'(i);
    return idx;
  endfunction

  // ticks earned this clock and leftover fine units
  function automatic logic [RW+2:0] res_ticks(input res_sel_e r, input logic [RW-1:0] s);
    logic [2:0]    k;
    logic [RW-1:0] nr;
    k  = '0;
    nr = '0;
    case (r)
      RES_10NS, RES_20NS, RES_40NS, RES_80NS, RES_160NS:
      begin
        k  = 3'(s >> r);
        nr = s & ((RW'(1) << r) - RW'(1));
      end
      RES_1600NS:
      begin
        k  = (s >= SLOW_UNITS) ? 3'd1 : 3'd0;
        nr = (s >= SLOW_UNITS) ? s - SLOW_UNITS : s;
      end
      default:
      begin
        k  = '0;
        nr = '0;
      end
    endcase
    return {k, nr};
  endfunction

  prf_state_e               state_q;
  res_sel_e                 res_q;
  logic [RW-1:0]            residue_q;
  logic [NUM_TASKS-1:0]     task_en_q;
  logic [NUM_BLOCKS-1:0]    blk_vld_q;
  logic [TASK_W-1:0]        blk_task_q [NUM_BLOCKS];
  logic                     act_vld_q;
  logic [BLK_W-1:0]         act_blk_q;
  logic [TIME_W-1:0]        time_q;
  logic [COUNT_W-1:0]       count_q;
  logic                     rd_pend_q;
  logic                     rd_live_q;
  logic [BLK_W-1:0]         rd_blk_q;
  logic [TIME_W+COUNT_W-1:0] mem_a;
  logic [TIME_W+COUNT_W-1:0] mem_b;

  // block lookup for the entering task and for a deselected task
  logic [NUM_BLOCKS-1:0] hit_vec;
  logic [NUM_BLOCKS-1:0] drop_vec;
  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++)
    begin : g_lookup
      assign hit_vec[g]  = blk_vld_q[g] && (blk_task_q[g] == task_id_i);
      assign drop_vec[g] = blk_vld_q[g] && (blk_task_q[g] == sel_id_i) && sel_we_i && !sel_en_i;
    end
  endgenerate

  // entry decode; entries during a reload or a clear are ignored
  wire              res_chg   = (res_sel_i != res_q) && (res_sel_i <= RES_1600NS);
  wire              clr_all   = clear_i || res_chg;
  wire              hit       = |hit_vec;
  wire              full      = &blk_vld_q;
  wire [BLK_W-1:0]  hit_idx   = first_set(hit_vec);
  wire [BLK_W-1:0]  free_idx  = first_set(~blk_vld_q);
  wire              enter_ok  = task_enter_i && task_en_q[task_id_i] && (state_q == ST_RUN) && !clr_all;
  wire              new_alloc = enter_ok && !hit && !full;
  wire              same_blk  = enter_ok && hit && act_vld_q && (hit_idx == act_blk_q);
  wire              switch_hit = enter_ok && hit && !same_blk;
  wire              act_drop  = act_vld_q && drop_vec[act_blk_q];
  wire              wb_en     = (new_alloc || switch_hit) && act_vld_q && !act_drop;

  // entry count, saturating at its maximum
  wire              loading   = (state_q == ST_LOAD);
  wire [COUNT_W-1:0] cnt_src  = loading ? mem_a[COUNT_W-1:0] : count_q;
  wire              cnt_bump  = loading || same_blk;
  wire              cnt_exc   = cnt_bump && (cnt_src == COUNT_MAX);
  wire [COUNT_W-1:0] cnt_next = !cnt_bump ? cnt_src : cnt_exc ? COUNT_MAX : cnt_src + COUNT_W'(1);
  wire [COUNT_W-1:0] count_d  = new_alloc ? COUNT_W'(1) : cnt_next;

  // time accumulation in ticks of the selected period
  wire [RW-1:0]     res_sum   = residue_q + STEP_UNITS;
  wire [RW+2:0]     tick_pack = res_ticks(res_q, res_sum);
  wire [2:0]        tick_k    = tick_pack[RW+2:RW];
  wire              time_run  = act_vld_q && task_run_i && !loading && !new_alloc && !switch_hit;
  wire [TIME_W:0]   time_sum  = {1'b0, time_q} + (TIME_W + 1)'(tick_k);
  wire              time_exc  = time_run && time_sum[TIME_W];
  wire [TIME_W-1:0] time_next = !time_run ? time_q : time_exc ? TIME_MAX : time_sum[TIME_W-1:0];
  wire [TIME_W-1:0] time_d    = loading ? mem_a[TIME_W+COUNT_W-1:COUNT_W] : new_alloc ? '0 : time_next;
  // raw exceed, not gated by a clear, so an event beats a clear on the flag
  wire              ovf_now   = time_exc || cnt_exc;

  // results of inactive blocks live in the memory
  profile_result_mem #(
    .DEPTH (NUM_BLOCKS),
    .AW    (BLK_W),
    .W     (TIME_W + COUNT_W)
  ) u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (clr_all),
    .we_i      (wb_en),
    .waddr_i   (act_blk_q),
    .wdata_i   ({time_q, count_q}),
    .ra_addr_i (hit_idx),
    .ra_data_o (mem_a),
    .rb_addr_i (rd_block_i),
    .rb_data_o (mem_b)
  );

  // tick period and its fine-unit residue
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      res_q     <= RES_10NS;
      residue_q <= '0;
    end
    else
    begin
      if (res_chg)
        res_q <= res_sel_i;
      residue_q <= clr_all ? '0 : tick_pack[RW-1:0];
    end
  end

  // task enables start all set; selection by the debugger
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      task_en_q <= '1;
    else if (sel_we_i)
      task_en_q[sel_id_i] <= sel_en_i;
  end

  // block ownership; deselection frees the block
  generate
    for (g = 0; g < NUM_BLOCKS; g++)
    begin : g_alloc
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          blk_vld_q[g]  <= 1'b0;
          blk_task_q[g] <= '0;
        end
        else if (new_alloc && (free_idx == BLK_W'(g)))
        begin
          blk_vld_q[g]  <= 1'b1;
          blk_task_q[g] <= task_id_i;
        end
        else if (drop_vec[g])
          blk_vld_q[g] <= 1'b0;
      end
    end
  endgenerate

  // active block, its live counters and the reload step
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q   <= ST_RUN;
      act_vld_q <= 1'b0;
      act_blk_q <= '0;
      time_q    <= '0;
      count_q   <= '0;
    end
    else if (clr_all)
    begin
      state_q <= ST_RUN;
      time_q  <= '0;
      count_q <= '0;
      act_vld_q <= act_vld_q && !act_drop;
    end
    else
    begin
      state_q   <= switch_hit ? ST_LOAD : ST_RUN;
      act_vld_q <= (new_alloc || switch_hit) || (act_vld_q && !act_drop);
      act_blk_q <= new_alloc ? free_idx : switch_hit ? hit_idx : act_blk_q;
      time_q    <= time_d;
      count_q   <= count_d;
    end
  end

  // overflow event pulse and sticky flag; an event beats a clear
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ovf_event_o <= 1'b0;
      ovf_flag_o  <= 1'b0;
      ovf_break_o <= 1'b0;
      ovf_trace_o <= 1'b0;
    end
    else
    begin
      ovf_event_o <= ovf_now;
      ovf_flag_o  <= ovf_now || (ovf_flag_o && !clr_all);
      ovf_break_o <= ovf_now && brk_en_i;
      ovf_trace_o <= ovf_now && trc_en_i;
    end
  end

  // host read; the active block is served from its live counters, except in a reload cycle, when it comes from the memory
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_pend_q     <= 1'b0;
      rd_live_q     <= 1'b0;
      rd_blk_q      <= '0;
      rd_valid_o    <= 1'b0;
      rd_alloc_o    <= 1'b0;
      rd_task_o     <= '0;
      rd_time_o     <= '0;
      rd_count_o    <= '0;
      blocks_full_o <= 1'b0;
    end
    else
    begin
      rd_pend_q     <= rd_req_i;
      rd_live_q     <= act_vld_q && (act_blk_q == rd_block_i) && !loading;
      rd_blk_q      <= rd_block_i;
      rd_valid_o    <= rd_pend_q;
      blocks_full_o <= full;
      if (rd_pend_q)
      begin
        rd_alloc_o <= blk_vld_q[rd_blk_q];
        rd_task_o  <= blk_task_q[rd_blk_q];
        rd_time_o  <= rd_live_q ? time_q : mem_b[TIME_W+COUNT_W-1:COUNT_W];
        rd_count_o <= rd_live_q ? count_q : mem_b[COUNT_W-1:0];
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_enter_free;
    enter_ok && !hit && !full;
  endsequence

  sequence s_rd;
    rd_req_i ##1 rd_pend_q;
  endsequence

  AST_ALLOC_FREE: assert property (s_enter_free |=> act_vld_q && blk_vld_q[act_blk_q] && count_q == COUNT_W'(1))
    else $error("free block not allocated on entry");
  AST_FULL_REFUSE: assert property (enter_ok && !hit && full && !(|drop_vec) |=> $stable(blk_vld_q))
    else $error("allocation happened with all blocks in use");
  AST_DISABLED_IGNORED: assert property (task_enter_i && !task_en_q[task_id_i] && !act_vld_q && !clr_all
    |=> !act_vld_q)
    else $error("disabled task became active");
  AST_CLEAR_ZERO: assert property (clear_i |=> time_q == '0 && count_q == '0 && residue_q == '0)
    else $error("clear left results");
  AST_SLOW_TICK: assert property (res_q == RES_1600NS && tick_k != 3'd0 && !clr_all
    |=> (tick_k == 3'd0)[*8])
    else $error("slow tick period too short");
  AST_RES_CLEAR: assert property (res_chg |=> time_q == '0 && res_q == $past(res_sel_i))
    else $error("period change did not clear");
  AST_TIME_HOLD: assert property (!task_run_i && !loading && !clr_all && !new_alloc && !switch_hit
    |=> time_q == $past(time_q))
    else $error("time moved while task not running");
  AST_CNT_OVF: assert property (cnt_exc && !clr_all |=> count_q == COUNT_MAX && ovf_event_o)
    else $error("count overflow not saturated or flagged");
  AST_TIME_OVF: assert property (time_exc && !clr_all |=> time_q == TIME_MAX ##0 ovf_flag_o)
    else $error("time overflow not saturated or flagged");
  AST_OVF_BREAK: assert property (ovf_break_o == (ovf_event_o && $past(brk_en_i))
    && ovf_trace_o == (ovf_event_o && $past(trc_en_i)))
    else $error("break or trace request mismatch");
  AST_SAT_HOLD: assert property (time_q == TIME_MAX && time_run && !clr_all |=> time_q == TIME_MAX)
    else $error("saturated time wrapped");
  AST_READ: assert property (s_rd |=> rd_valid_o)
    else $error("read answer missing");

endmodule
`default_nettype wire

// >>> bench/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic                  clk_i,
  output logic                       sel_we_o,
  output logic      [3:0]            sel_id_o,
  output logic                       sel_en_o,
  output var profile_pkg::res_sel_e  res_sel_o,
  output logic                       clear_o,
  output logic                       rd_req_o,
  output logic      [2:0]            rd_block_o,
  input  wire logic                  rd_valid_i,
  input  wire logic                  rd_alloc_i,
  input  wire logic [3:0]            rd_task_i,
  input  wire logic [39:0]           rd_time_i,
  input  wire logic [15:0]           rd_count_i
);
  import profile_pkg::*;
  logic        got_ok;
  logic        got_alloc;
  logic [3:0]  got_task;
  logic [39:0] got_time;
  logic [15:0] got_count;

  // quiet bus from time zero
  initial
  begin
    sel_we_o = 1'b0;
    sel_id_o = 4'h0;
    sel_en_o = 1'b1;
    res_sel_o = RES_10NS;
    clear_o = 1'b0;
    rd_req_o = 1'b0;
    rd_block_o = 3'h0;
  end

  // enable write: one-cycle pulse, id inverted afterwards so stale ids never match
  task automatic pulse_sel(input logic [3:0] id, input logic en);
    @(posedge clk_i);
    #1;
    sel_we_o = 1'b1;
    sel_id_o = id;
    sel_en_o = en;
    @(posedge clk_i);
    #1;
    sel_we_o = 1'b0;
    sel_id_o = ~id;
  endtask

  task automatic pulse_clear;
    @(posedge clk_i);
    #1;
    clear_o = 1'b1;
    @(posedge clk_i);
    #1;
    clear_o = 1'b0;
  endtask

  // period is a level; the edge after the change takes it
  task automatic set_res(input res_sel_e v);
    @(posedge clk_i);
    #1;
    res_sel_o = v;
    @(posedge clk_i);
  endtask

  // answer comes two edges after the request; waits at most four
  task automatic read_blk(input logic [2:0] b);
    int n;
    @(posedge clk_i);
    #1;
    rd_req_o = 1'b1;
    rd_block_o = b;
    @(posedge clk_i);
    #1;
    rd_req_o = 1'b0;
    rd_block_o = ~b;
    got_ok = 1'b0;
    for (n = 0; n < 4 && !got_ok; n++)
    begin
      @(posedge clk_i);
      #1;
      if (rd_valid_i === 1'b1)
      begin
        got_ok = 1'b1;
        got_alloc = rd_alloc_i;
        got_task = rd_task_i;
        got_time = rd_time_i;
        got_count = rd_count_i;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import profile_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        task_enter_i = 1'b0;
  logic [3:0]  task_id_i = 4'h0;
  logic        task_run_i = 1'b0;
  logic        brk_en_i = 1'b0;
  logic        trc_en_i = 1'b0;
  logic        sel_we, sel_en, clear, rd_req, rd_valid, rd_alloc;
  logic [3:0]  sel_id, rd_task;
  logic [2:0]  rd_block;
  logic [39:0] rd_time;
  logic [15:0] rd_count;
  logic        blocks_full, ovf_event, ovf_flag, ovf_break, ovf_trace;
  res_sel_e    res_sel;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #25 clk_i = ~clk_i;

  realtime_profile_counter dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .task_enter_i(task_enter_i),
    .task_id_i(task_id_i), .task_run_i(task_run_i), .sel_we_i(sel_we), .sel_id_i(sel_id),
    .sel_en_i(sel_en), .res_sel_i(res_sel), .clear_i(clear), .brk_en_i(brk_en_i), .trc_en_i(trc_en_i),
    .rd_req_i(rd_req), .rd_block_i(rd_block), .rd_valid_o(rd_valid), .rd_alloc_o(rd_alloc),
    .rd_task_o(rd_task), .rd_time_o(rd_time), .rd_count_o(rd_count), .blocks_full_o(blocks_full),
    .ovf_event_o(ovf_event), .ovf_flag_o(ovf_flag), .ovf_break_o(ovf_break), .ovf_trace_o(ovf_trace));

  host_model host_u (.clk_i(clk_i), .sel_we_o(sel_we), .sel_id_o(sel_id), .sel_en_o(sel_en),
    .res_sel_o(res_sel), .clear_o(clear), .rd_req_o(rd_req), .rd_block_o(rd_block),
    .rd_valid_i(rd_valid), .rd_alloc_i(rd_alloc), .rd_task_i(rd_task), .rd_time_i(rd_time),
    .rd_count_i(rd_count));

  // hang guard: the overflow test alone needs about 66k cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_errors++;
      $display("MISMATCH t=%0t run too long", $time);
      conclude();
    end
  end

  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  task automatic expect_blk(input logic [2:0] b, input logic [3:0] id, input logic [39:0] tm,
                            input logic [15:0] cn);
    host_u.read_blk(b);
    check(host_u.got_ok === 1'b1 && host_u.got_alloc === 1'b1 && host_u.got_task === id
          && host_u.got_time === tm && host_u.got_count === cn, "read block");
  endtask

  // entry pulse, then idle so no entry lands in a reload cycle
  task automatic enter(input logic [3:0] id);
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b1;
    task_id_i = id;
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic t_alloc;
    enter(4'h3);
    enter(4'h3);
    enter(4'h3);
    expect_blk(3'h0, 4'h3, 40'h0, 16'h0003);
    enter(4'h6);
    expect_blk(3'h1, 4'h6, 40'h0, 16'h0001);
    expect_blk(3'h0, 4'h3, 40'h0, 16'h0003);
    $display("test alloc done");
  endtask

  task automatic t_clear;
    host_u.pulse_clear();
    expect_blk(3'h0, 4'h3, 40'h0, 16'h0000);
    $display("test clear done");
  endtask

  // 32 running clocks = 160 fine units, so each period gives an exact tick count
  task automatic t_res;
    int k;
    int units [6] = '{1, 2, 4, 8, 16, 160};
    for (k = 5; k >= 0; k--)
    begin
      host_u.set_res(res_sel_e'(k));
      @(posedge clk_i);
      #1;
      task_run_i = 1'b1;
      repeat (32) @(posedge clk_i);
      #1;
      task_run_i = 1'b0;
      expect_blk(3'h1, 4'h6, 40'(160 / units[k]), 16'h0000);
    end
    $display("test resolution done");
  endtask

  task automatic t_full;
    int i;
    logic [3:0] ids [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7};
    for (i = 0; i < 6; i++)
      enter(ids[i]);
    check(blocks_full === 1'b1, "not full after eight");
    enter(4'h8);
    expect_blk(3'h7, 4'h7, 40'h0, 16'h0001);
    host_u.pulse_sel(4'h3, 1'b0);
    host_u.read_blk(3'h0);
    check(host_u.got_ok === 1'b1 && host_u.got_alloc === 1'b0, "freed block still owned");
    enter(4'h3);
    check(blocks_full === 1'b0, "disabled task took a block");
    enter(4'h8);
    expect_blk(3'h0, 4'h8, 40'h0, 16'h0001);
    check(blocks_full === 1'b1, "not full again");
    $display("test full done");
  endtask

  task automatic t_ovf;
    int n;
    brk_en_i = 1'b1;
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b1;
    task_id_i = 4'h8;
    repeat (65534) @(posedge clk_i);
    #1;
    task_enter_i = 1'b0;
    repeat (2) @(posedge clk_i);
    check(ovf_flag === 1'b0, "early overflow");
    expect_blk(3'h0, 4'h8, 40'h0, 16'hffff);
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b1;
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b0;
    n = 0;
    while (ovf_event !== 1'b1 && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(ovf_event === 1'b1 && ovf_break === 1'b1 && ovf_trace === 1'b0, "overflow event");
    check(ovf_flag === 1'b1, "flag not set");
    expect_blk(3'h0, 4'h8, 40'h0, 16'hffff);
    // second exceed routed to trace only
    brk_en_i = 1'b0;
    trc_en_i = 1'b1;
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b1;
    @(posedge clk_i);
    #1;
    task_enter_i = 1'b0;
    check(ovf_event === 1'b1 && ovf_break === 1'b0 && ovf_trace === 1'b1, "trace event");
    @(posedge clk_i);
    #1;
    check(ovf_event === 1'b0 && ovf_trace === 1'b0, "event longer than one cycle");
    trc_en_i = 1'b0;
    host_u.pulse_clear();
    repeat (2) @(posedge clk_i);
    check(ovf_flag === 1'b0, "flag kept after clear");
    $display("test overflow done");
  endtask

  // reload path: an owned but inactive task becomes active again
  task automatic t_switch;
    enter(4'h6);
    @(posedge clk_i);
    #1;
    task_run_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    task_run_i = 1'b0;
    expect_blk(3'h1, 4'h6, 40'h14, 16'h0001);
    enter(4'h8);
    expect_blk(3'h0, 4'h8, 40'h0, 16'h0001);
    expect_blk(3'h1, 4'h6, 40'h14, 16'h0001);
    host_u.set_res(RES_20NS);
    expect_blk(3'h0, 4'h8, 40'h0, 16'h0000);
    expect_blk(3'h1, 4'h6, 40'h0, 16'h0000);
    $display("test switch done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    t_alloc();
    t_clear();
    t_res();
    t_full();
    t_ovf();
    t_switch();
    conclude();
  end
endmodule
`default_nettype wire
